//--- rtl/frsc_defs.svh
// Constants for the flash rewrite status and control block.
// Assumes an APB slave with 32-bit data and byte addresses.
`ifndef FRSC_DEFS_SVH
`define FRSC_DEFS_SVH
// Register indices; each word sits at four times its index
`define FRSC_STATUS_IDX  10'h1b2
`define FRSC_CTRL0_IDX   10'h1b4
`define FRSC_CMD_IDX     10'h1b8
`define FRSC_STATUS_ADDR {`FRSC_STATUS_IDX, 2'b00}
`define FRSC_CTRL0_ADDR  {`FRSC_CTRL0_IDX, 2'b00}
`define FRSC_CMD_ADDR    {`FRSC_CMD_IDX, 2'b00}
`define FRSC_ADDR_W      12
`define FRSC_B_RDY_EV    0
`define FRSC_B_ACC_ERR   1
`define FRSC_B_LOCK      2
`define FRSC_B_PRG_ERR   4
`define FRSC_B_ERS_ERR   5
`define FRSC_B_SUSP      6
`define FRSC_B_READY     7
`define FRSC_C_REWRITE   1
`define FRSC_C_MODE      2
`define FRSC_C_STOP      3
`define FRSC_C_ABORT     4
`define FRSC_C_CMDERR_EN 5
`define FRSC_C_ACCERR_EN 6
`define FRSC_C_RDY_EN    7
`define FRSC_OP_TIME     8'h20
`define FRSC_ABORT_TIME  8'h04
`define FRSC_STOP_TIME   8'h08
`define FRSC_CNT_ZERO    8'h00
`define FRSC_CNT_ONE     8'h01
`endif

//--- rtl/frsc_pkg.sv
// Types for the flash rewrite status and control block.
// Assumes the constants header is included where numbers are needed.
package frsc_pkg;
    typedef enum logic [2:0] {
        FRSC_OP_NONE,
        FRSC_OP_PROGRAM,
        FRSC_OP_ERASE,
        FRSC_OP_LOCK_PROG,
        FRSC_OP_LOCK_READ,
        FRSC_OP_BLANK,
        FRSC_OP_CLEAR
    } frsc_op_t;
    typedef enum logic [1:0] {
        FRSC_ST_READY,
        FRSC_ST_BUSY,
        FRSC_ST_SUSPEND
    } frsc_state_t;
    typedef struct packed {
        logic fail;
        logic lock_state;
        logic data_area;
    } frsc_core_t;
endpackage

//--- rtl/frsc_timer.sv
// Busy timer for the rewrite sequencer.
// Assumes a load pulse starts a countdown; done pulses when it expires.
`timescale 1ns/1ps
`include "frsc_defs.svh"
module frsc_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       load,
    input  wire logic [7:0] count,
    // Status
    output logic            running,
    output logic            done
);
    logic [7:0] cnt_ff;
    logic       done_ff;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            cnt_ff <= `FRSC_CNT_ZERO;
        else if (load)
            cnt_ff <= count;
        else if (cnt_ff != `FRSC_CNT_ZERO)
            cnt_ff <= cnt_ff - `FRSC_CNT_ONE;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            done_ff <= 1'b0;
        else
            done_ff <= !load && (cnt_ff == `FRSC_CNT_ONE);
    end

    assign running = (cnt_ff != `FRSC_CNT_ZERO);
    assign done    = done_ff;
endmodule

//--- rtl/frsc_top.sv
// Status and control registers of the flash rewrite sequencer.
// Assumes an APB master on clk; flash array model is outside.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "frsc_defs.svh"

module frsc_top (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Flash core side
    input  wire frsc_pkg::frsc_core_t    core_in,
    input  wire logic                    suspend_req,
    input  wire logic                    busy_area_access,
    input  wire logic                    data_area_read,
    input  wire logic                    cmd_seq_error,
    // Flash side outputs
    output logic                         flash_low_power,
    output logic                         flash_read_block,
    output logic                         erase_write_mode_one,
    output logic                         read_data_undefined
);
    logic [7:0]            ctrl_ff;
    logic                  ready_ff;
    logic                  rdy_ev_ff;
    logic                  acc_err_ff;
    logic                  lock_ff;
    logic                  prg_err_ff;
    logic                  ers_err_ff;
    logic                  susp_ff;
    logic                  stop_ff;
    logic                  pready_ff;
    logic [31:0]           prdata_ff;
    logic                  pslverr_ff;
    logic                  undef_ff;
    logic                  prog_area_ff;
    frsc_pkg::frsc_state_t state_ff;
    frsc_pkg::frsc_op_t    op_ff;
    logic                  wr_acc;
    logic                  rd_acc;
    logic                  wr_status;
    logic                  wr_ctrl;
    logic                  wr_cmd;
    logic                  abort_go;
    logic                  stop_on;
    logic                  stop_off;
    logic                  start_cmd;
    logic                  tmr_load;
    logic [7:0]            tmr_count;
    logic                  tmr_running;
    logic                  tmr_done;
    logic                  busy_now;
    logic                  to_ready;
    logic                  cmd_err;
    logic                  nxt_ready;
    frsc_pkg::frsc_op_t    cmd_op;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a[11:2] == r[11:2]);
    endfunction

    assign wr_acc    = psel && penable && pwrite && !pready_ff;
    assign rd_acc    = psel && penable && !pwrite && !pready_ff;
    assign wr_status = wr_acc && hit(paddr, `FRSC_STATUS_ADDR);
    assign wr_ctrl   = wr_acc && hit(paddr, `FRSC_CTRL0_ADDR);
    assign wr_cmd    = wr_acc && hit(paddr, `FRSC_CMD_ADDR);
    assign cmd_op    = frsc_pkg::frsc_op_t'(pwdata[2:0]);
    assign busy_now  = (state_ff == frsc_pkg::FRSC_ST_BUSY);
    assign abort_go  = wr_ctrl && pwdata[`FRSC_C_ABORT]
        && ctrl_ff[`FRSC_C_REWRITE] && busy_now;
    assign stop_on   = wr_ctrl && pwdata[`FRSC_C_STOP] && !stop_ff
        && ctrl_ff[`FRSC_C_REWRITE] && ready_ff;
    assign stop_off  = stop_ff && (!ctrl_ff[`FRSC_C_REWRITE]
        || (wr_ctrl && !pwdata[`FRSC_C_STOP]));
    assign start_cmd = wr_cmd && ctrl_ff[`FRSC_C_REWRITE] && !stop_ff
        && ready_ff && (cmd_op != frsc_pkg::FRSC_OP_NONE)
        && (cmd_op != frsc_pkg::FRSC_OP_CLEAR);
    assign cmd_err   = (tmr_done && busy_now && core_in.fail) || cmd_seq_error;

    always_comb
    begin
        tmr_load  = 1'b0;
        tmr_count = `FRSC_OP_TIME;
        if (abort_go)
        begin
            tmr_load  = 1'b1;
            tmr_count = `FRSC_ABORT_TIME;
        end
        else if (stop_on || stop_off)
        begin
            tmr_load  = 1'b1;
            tmr_count = `FRSC_STOP_TIME;
        end
        else if (start_cmd || (state_ff == frsc_pkg::FRSC_ST_SUSPEND
            && !suspend_req))
            tmr_load = 1'b1;
    end

    frsc_timer u_timer (
        .clk     (clk),
        .nrst    (nrst),
        .load    (tmr_load),
        .count   (tmr_count),
        .running (tmr_running),
        .done    (tmr_done)
    );

    // Resume restarts the erase; the timer cannot hold its count
    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_ff <= frsc_pkg::FRSC_ST_READY;
        else
            case (state_ff)
                frsc_pkg::FRSC_ST_READY:
                    if (tmr_load)
                        state_ff <= frsc_pkg::FRSC_ST_BUSY;
                frsc_pkg::FRSC_ST_BUSY:
                    if (abort_go)
                        state_ff <= frsc_pkg::FRSC_ST_BUSY;
                    else if (suspend_req
                        && op_ff == frsc_pkg::FRSC_OP_ERASE)
                        state_ff <= frsc_pkg::FRSC_ST_SUSPEND;
                    else if (tmr_done)
                        state_ff <= frsc_pkg::FRSC_ST_READY;
                frsc_pkg::FRSC_ST_SUSPEND:
                    if (start_cmd || !suspend_req)
                        state_ff <= frsc_pkg::FRSC_ST_BUSY;
                default:
                    state_ff <= frsc_pkg::FRSC_ST_READY;
            endcase
    end

    assign to_ready = busy_now && !abort_go
        && ((tmr_done && !tmr_load) || (suspend_req
        && op_ff == frsc_pkg::FRSC_OP_ERASE));

    always_ff @(posedge clk)
    begin
        if (!nrst)
            op_ff <= frsc_pkg::FRSC_OP_NONE;
        else if (abort_go || stop_on || stop_off)
            op_ff <= frsc_pkg::FRSC_OP_NONE;
        else if (start_cmd)
            op_ff <= cmd_op;
    end

    // Ready flag is 0 in busy, 1 in ready and suspend
    always_comb
    begin
        nxt_ready = 1'b1;
        if (tmr_load || (busy_now && !to_ready))
            nxt_ready = 1'b0;
        if (state_ff == frsc_pkg::FRSC_ST_SUSPEND && !suspend_req)
            nxt_ready = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            ready_ff <= 1'b1;
        else
            ready_ff <= nxt_ready;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            susp_ff <= 1'b0;
        else
            susp_ff <= (nxt_ready && suspend_req
                && (state_ff != frsc_pkg::FRSC_ST_READY)
                && op_ff == frsc_pkg::FRSC_OP_ERASE
                && !abort_go);
    end

    // Set wins over clear; only writing 0 clears
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdy_ev_ff <= 1'b0;
        else if (!ready_ff && nxt_ready && ctrl_ff[`FRSC_C_RDY_EN])
            rdy_ev_ff <= 1'b1;
        else if (wr_status && !pwdata[`FRSC_B_RDY_EV])
            rdy_ev_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            acc_err_ff <= 1'b0;
        else if ((busy_area_access && !ready_ff
            && ctrl_ff[`FRSC_C_ACCERR_EN])
            || (data_area_read && !ready_ff && prog_area_ff)
            || (cmd_err && ctrl_ff[`FRSC_C_CMDERR_EN]))
            acc_err_ff <= 1'b1;
        else if ((wr_status && !pwdata[`FRSC_B_ACC_ERR])
            || (wr_cmd && cmd_op == frsc_pkg::FRSC_OP_CLEAR))
            acc_err_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            prog_area_ff <= 1'b0;
        else if (start_cmd)
            prog_area_ff <= !core_in.data_area;
    end

    // Undefined read marker for the data area during program area rewrite
    always_ff @(posedge clk)
    begin
        if (!nrst)
            undef_ff <= 1'b0;
        else
            undef_ff <= data_area_read && !ready_ff && prog_area_ff;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            lock_ff <= 1'b1;
        else if (to_ready && (op_ff == frsc_pkg::FRSC_OP_LOCK_READ
            || op_ff == frsc_pkg::FRSC_OP_PROGRAM
            || op_ff == frsc_pkg::FRSC_OP_ERASE))
            lock_ff <= core_in.lock_state;
    end

    // Error flags hold until the next command or clear status
    always_ff @(posedge clk)
    begin
        if (!nrst)
            prg_err_ff <= 1'b0;
        else if (cmd_seq_error
            || (tmr_done && core_in.fail
            && op_ff == frsc_pkg::FRSC_OP_PROGRAM))
            prg_err_ff <= 1'b1;
        else if (start_cmd || (wr_cmd && cmd_op == frsc_pkg::FRSC_OP_CLEAR))
            prg_err_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            ers_err_ff <= 1'b0;
        else if (cmd_seq_error
            || (tmr_done && busy_now && core_in.fail
            && (op_ff == frsc_pkg::FRSC_OP_ERASE
            || op_ff == frsc_pkg::FRSC_OP_BLANK)))
            ers_err_ff <= 1'b1;
        else if (start_cmd || (wr_cmd && cmd_op == frsc_pkg::FRSC_OP_CLEAR))
            ers_err_ff <= 1'b0;
    end

    // Abort bit is never stored, so it always reads 0
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ctrl_ff <= 8'h00;
        else if (wr_ctrl)
            ctrl_ff <= pwdata[7:0] & 8'he6;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            stop_ff <= 1'b0;
        else if (stop_on)
            stop_ff <= 1'b1;
        else if (stop_off)
            stop_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            flash_low_power      <= 1'b0;
            flash_read_block     <= 1'b0;
            erase_write_mode_one <= 1'b0;
            read_data_undefined  <= 1'b0;
        end
        else
        begin
            flash_low_power      <= stop_ff;
            flash_read_block     <= stop_ff || (tmr_running
                && !ready_ff);
            erase_write_mode_one <= ctrl_ff[`FRSC_C_MODE];
            read_data_undefined  <= undef_ff;
        end
    end

    // APB: one wait state, every access answers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= (wr_acc || rd_acc) && !hit(paddr,
                `FRSC_STATUS_ADDR) && !hit(paddr, `FRSC_CTRL0_ADDR)
                && !hit(paddr, `FRSC_CMD_ADDR);
            prdata_ff  <= 32'h0;
            if (rd_acc && hit(paddr, `FRSC_STATUS_ADDR))
                prdata_ff[7:0] <= {ready_ff, susp_ff, ers_err_ff,
                    prg_err_ff, 1'b0, lock_ff, acc_err_ff, rdy_ev_ff};
            else if (rd_acc && hit(paddr, `FRSC_CTRL0_ADDR))
                prdata_ff[7:0] <= {ctrl_ff[7:4], stop_ff, ctrl_ff[2:0]};
        end
    end

    assign pready  = pready_ff;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    ready_rise_a: assert property (@(posedge clk) disable iff (!nrst)
        (!ready_ff && nxt_ready && ctrl_ff[`FRSC_C_RDY_EN])
        |=> rdy_ev_ff) else $error("ready event lost");
    ready_busy_a: assert property (@(posedge clk) disable iff (!nrst)
        start_cmd |=> !ready_ff) else $error("ready after start");
    acc_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmd_seq_error && ctrl_ff[`FRSC_C_CMDERR_EN]) |=> acc_err_ff)
        else $error("command error not flagged");
    no_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (!rdy_ev_ff && wr_status && ready_ff && !to_ready) |=> !rdy_ev_ff)
        else $error("software set event flag");
    abort_ready_a: assert property (@(posedge clk) disable iff (!nrst)
        abort_go |-> ##[1:8] ready_ff) else $error("abort too slow");
    stop_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ctrl && !ctrl_ff[`FRSC_C_REWRITE]) |=> !stop_ff)
        else $error("stop without rewrite");
    err_seq_a: assert property (@(posedge clk) disable iff (!nrst)
        cmd_seq_error |=> prg_err_ff && ers_err_ff)
        else $error("error flags not set");
    mode_out_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 erase_write_mode_one == $past(ctrl_ff[`FRSC_C_MODE]))
        else $error("mode output wrong");
endmodule

//--- tb/frsc_tb.sv
// Self-checking bench for the flash rewrite status and control block.
// Assumes frsc_top, its constants header and package; one 10 MHz clock.
`timescale 1ns/1ps
`include "frsc_defs.svh"
module tb_top;
    localparam logic [11:0] st_a  = `FRSC_STATUS_ADDR;
    localparam logic [11:0] c0_a  = `FRSC_CTRL0_ADDR;
    localparam logic [11:0] cmd_a = `FRSC_CMD_ADDR;
    // Clock, reset and APB
    logic                 clk;
    logic                 nrst;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    // Flash core side
    frsc_pkg::frsc_core_t core_in;
    logic                 suspend_req;
    logic                 busy_area_access;
    logic                 data_area_read;
    logic                 cmd_seq_error;
    logic                 flash_low_power;
    logic                 flash_read_block;
    logic                 erase_write_mode_one;
    logic                 read_data_undefined;
    // Bench state
    int                   fails;
    int                   compares;
    int                   seed;
    logic [31:0]          rv;
    logic                 f;
    logic                 lk;
    logic                 hit;
    logic [7:0]           e;
    logic [7:0]           m;
    logic [31:0]          exp_q[$];
    logic [31:0]          msk_q[$];
    logic                 err_q[$];

    frsc_top uut (
        .clk                  (clk),
        .nrst                 (nrst),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pready               (pready),
        .prdata               (prdata),
        .pslverr              (pslverr),
        .core_in              (core_in),
        .suspend_req          (suspend_req),
        .busy_area_access     (busy_area_access),
        .data_area_read       (data_area_read),
        .cmd_seq_error        (cmd_seq_error),
        .flash_low_power      (flash_low_power),
        .flash_read_block     (flash_read_block),
        .erase_write_mode_one (erase_write_mode_one),
        .read_data_undefined  (read_data_undefined)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] msk, input string what);
        compares++;
        if (((got ^ exp) & msk) !== 32'h0)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk({31'h0, got}, {31'h0, exp}, 32'h1, what);
    endtask

    // Answer monitor: oldest note against each completed transfer
    always @(posedge clk)
    begin
        if (nrst && psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk1(1'b1, 1'b0, "unexpected answer");
            else
            begin
                chk1(pslverr, err_q.pop_front(), "slave error");
                chk(prdata, exp_q.pop_front(), msk_q.pop_front(), "data");
            end
        end
    end

    // One APB transfer; request held until pready seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [31:0] ex,
                        input logic [31:0] mk, input logic er);
        int n;
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        err_q.push_back(er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rv = prdata;
        if (n >= 50)
            chk1(1'b0, 1'b1, "no answer");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d}, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] ex,
                      input logic [7:0] mk);
        xfer(1'b0, a, 32'h0, {24'h0, ex}, {24'hffffff, mk}, 1'b0);
    endtask

    // Polls without judging data; the slave error, answer and loop bound checks can fail
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, st_a, 32'h0, 32'h0, 32'h0, 1'b0);
            n++;
        end
        while (rv[7] !== 1'b1 && n < 60);
        if (n >= 60)
            chk1(1'b0, 1'b1, "stuck busy");
    endtask

    task automatic pulse(input logic [2:0] v);
        {busy_area_access, data_area_read, cmd_seq_error} <= v;
        @(posedge clk);
        {busy_area_access, data_area_read, cmd_seq_error} <= 3'b000;
    endtask

    task automatic op(input logic [2:0] c);
        wr(cmd_a, {5'h0, c});
        rd(st_a, 8'h00, 8'h80);
    endtask

    task automatic clr_flags();
        wr(cmd_a, 8'h06);
        wait_rdy();
        xfer(1'b0, st_a, 32'h0, 32'h0, 32'h0, 1'b0);
        wr(st_a, 8'h00);
        wr(st_a, 8'hff);
        rd(st_a, 8'h80, 8'hf3);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        seed = 32'h1766;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        core_in = 3'b000;
        suspend_req = 1'b0;
        {busy_area_access, data_area_read, cmd_seq_error} = 3'b000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(st_a, 8'h84, 8'hff);
        rd(c0_a, 8'h00, 8'hff);
        xfer(1'b0, 12'h1bc, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        xfer(1'b1, 12'h1b0, 32'hff, 32'h0, 32'h0, 1'b1);
        wr(c0_a, 8'h08);
        chk1(flash_low_power, 1'b0, "stop while disabled");
        wr(c0_a, 8'h00);
        wr(c0_a, 8'h02);
        wr(c0_a, 8'h06);
        rd(c0_a, 8'h06, 8'hff);
        chk1(erase_write_mode_one, 1'b1, "mode one");
        wr(c0_a, 8'h02);
        chk1(erase_write_mode_one, 1'b0, "mode zero");
        wr(c0_a, 8'he2);
        rd(c0_a, 8'he2, 8'hff);
        // Commands 1 to 5, random failure on 1, 2 and 5, random lock state
        for (int c = 1; c <= 5; c++)
        begin
            f = (c == 3 || c == 4) ? 1'b0 : 1'($random(seed));
            lk = 1'($random(seed));
            core_in <= {f, lk, 1'b0};
            op(3'(c));
            wait_rdy();
            e = {2'b10, f && (c == 2 || c == 5), f && c == 1, 1'b0, lk, f, 1'b1};
            m = (c == 4) ? 8'hf7 : 8'hf3;
            rd(st_a, e, m);
            wr(st_a, 8'hff);
            rd(st_a, e, m);
            clr_flags();
        end
        core_in <= 3'b000;
        op(3'h2);
        suspend_req <= 1'b1;
        wait_rdy();
        rd(st_a, 8'hc1, 8'hc1);
        suspend_req <= 1'b0;
        rd(st_a, 8'h00, 8'hc0);
        wait_rdy();
        clr_flags();
        op(3'h1);
        pulse(3'b100);
        wait_rdy();
        rd(st_a, 8'h82, 8'h82);
        clr_flags();
        wr(c0_a, 8'ha2);
        op(3'h1);
        pulse(3'b100);
        wait_rdy();
        rd(st_a, 8'h80, 8'h82);
        wr(c0_a, 8'he2);
        clr_flags();
        op(3'h1);
        pulse(3'b010);
        hit = 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            hit = hit | (read_data_undefined === 1'b1);
        end
        chk1(hit, 1'b1, "undefined read data");
        wait_rdy();
        rd(st_a, 8'h82, 8'h82);
        clr_flags();
        pulse(3'b001);
        rd(st_a, 8'hb2, 8'hb2);
        clr_flags();
        // Abort must end the op well before its full length
        op(3'h2);
        wr(c0_a, 8'hf2);
        rd(c0_a, 8'he2, 8'hff);
        rd(st_a, 8'h81, 8'h81);
        chk1(flash_read_block, 1'b0, "reads resumed");
        clr_flags();
        wr(c0_a, 8'hf2);
        rd(st_a, 8'h80, 8'h81);
        wr(c0_a, 8'hea);
        chk1(flash_low_power, 1'b1, "low power");
        wait_rdy();
        xfer(1'b0, st_a, 32'h0, 32'h0, 32'h0, 1'b0);
        wr(st_a, 8'h00);
        wr(c0_a, 8'he2);
        chk1(flash_low_power, 1'b0, "flash running");
        wait_rdy();
        rd(st_a, 8'h81, 8'h81);
        clr_flags();
        wr(c0_a, 8'h00);
        rd(c0_a, 8'h00, 8'hff);
        stop_test();
    end
endmodule
